// *** core/pol_cfg.svh ***
`ifndef POL_CFG_SVH
`define POL_CFG_SVH

// register byte offsets (one aligned 32-bit word each)
`define REG_CTRL 5'h00
`define REG_THR 5'h04
`define REG_VSET 5'h08
`define REG_IRATED 5'h0C
`define REG_STATUS 5'h10
`define REG_IRQ_STAT 5'h14
`define REG_IRQ_MASK 5'h18

// guard indices, also bit positions in CTRL latch field, STATUS and IRQ registers
`define G_OC 0
`define G_OV 1
`define G_UV 2
`define G_OT 3
`define G_TRK 4
`define N_GUARD 5

// CTRL fields
`define CTRL_TRK_EN 5
`define CTRL_REARM 8
`define CTRL_RST 6'h00

// THR fields and reset codes
`define THR_OC_LSB 0
`define THR_OV_LSB 4
`define THR_UV_LSB 6
`define THR_PG 8
`define THR_OC_RST 4'hA
`define THR_OV_RST 2'h2
`define THR_UV_RST 2'h0
`define THR_PG_RST 1'h0

// plain defaults for setpoint and rated current
`define VSET_RST 16'h04B0
`define IRATED_RST 16'h2000

// STATUS fields
`define ST_LATCH_LSB 5
`define ST_WARN 10
`define ST_PG 11
`define ST_OFF 12

// IRQ bits beyond the per-guard trip bits
`define IRQ_WARN 5
`define IRQ_PG 6
`define IRQ_W 7

// threshold figures, percent, mV and deg C
`define OC_BASE 8'h3C
`define OC_STEP 8'h0C
`define OC_MAXCODE 4'hA
`define OV_BASE 8'h6E
`define OV_STEP 8'h0A
`define OV_MAXCODE 2'h2
`define OV_FLOOR_MV 16'h03E8
`define UV_BASE 8'h4B
`define UV_STEP 8'h05
`define UV_MAXCODE 2'h2
`define PG_BASE 8'h5A
`define PG_STEP 8'h05
`define PG_UPPER 8'h6E
`define TRK_BAND_MV 16'h00FA
`define OT_OFF_C 8'h82
`define OT_ON_C 8'h78
`define WARN_ON_C 8'h78
`define WARN_HYST_C 8'h03

// timing
`define CLK_NS 40
`define FILT_NS 6000
`define FILT_CYC ((`FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define RETRY_MS 130
`define RETRY_CYC ((`RETRY_MS * 1000000) / `CLK_NS)

`endif

// *** core/pol_pkg.sv ***
package pol_pkg;
    typedef enum logic [2:0] {
        G_RUN  = 3'b001,
        G_COOL = 3'b010,
        G_LOCK = 3'b100
    } guard_state_t;
endpackage

// *** core/trip_filter.sv ***
`timescale 1ns/1ps
// output takes the input's level once it has differed for DLY cycles in a row
module trip_filter #(
    parameter int DLY = 1
) (
    input wire logic mclk_i,  // clock
    input wire logic nrst_i,  // async reset, low
    input wire logic cond_i,  // raw condition
    output logic cond_o       // qualified condition
);
    localparam int CW = $clog2(DLY + 1);
    logic [CW-1:0] cnt_r;
    logic q_r;

    assign cond_o = q_r;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_r <= 1'b0;
            cnt_r <= '0;
        end else if (cond_i == q_r) begin
            cnt_r <= '0;
        end else if (cnt_r == CW'(DLY - 1)) begin
            q_r <= cond_i;
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    chk_filter_full_delay: assert property ($changed(q_r) |-> $past(cnt_r) == CW'(DLY - 1) && $past(cond_i) == q_r)
        else $error("filter output changed before its delay ran out");
    chk_filter_glitch_reset: assert property (cond_i == q_r |=> cnt_r == '0 && $stable(q_r))
        else $error("filter kept counting after the input returned");
endmodule

// *** core/fault_guard.sv ***
`timescale 1ns/1ps
// one protection: turn off on trip, then retry each period or lock until re-armed
module fault_guard
    import pol_pkg::*;
#(
    parameter int RETRY = 1
) (
    input wire logic mclk_i,       // clock
    input wire logic nrst_i,       // async reset, low
    input wire logic trip_i,       // qualified fault
    input wire logic latch_i,      // 1 = latching response
    input wire logic restart_ok_i, // restart allowed at end of period
    input wire logic rearm_i,      // software re-enable pulse
    output logic off_o,            // turn-off command
    output logic latched_o,        // locked off
    output logic trip_evt_o        // one-cycle trip event
);
    localparam int RW = $clog2(RETRY + 1);
    guard_state_t st_r;
    logic [RW-1:0] cnt_r;
    logic period_end;

    assign period_end = (cnt_r == RW'(RETRY - 1));
    assign off_o = (st_r != G_RUN);
    assign latched_o = (st_r == G_LOCK);
    assign trip_evt_o = (st_r == G_RUN) && trip_i;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= G_RUN;
        end else begin
            case (st_r)
                G_RUN: begin
                    if (trip_i) begin
                        st_r <= latch_i ? G_LOCK : G_COOL;
                    end
                end
                G_COOL: begin
                    if (period_end && restart_ok_i) begin
                        st_r <= G_RUN;
                    end
                end
                G_LOCK: begin
                    // a hot overtemperature guard ignores re-arm until it has cooled
                    if (rearm_i && restart_ok_i) begin
                        st_r <= G_RUN;
                    end
                end
                default: st_r <= G_RUN;
            endcase
        end
    end

    // a refused restart simply begins another full period
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= '0;
        end else if (st_r != G_COOL || period_end) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    chk_trip_turns_off: assert property (st_r == G_RUN && trip_i |=> off_o && latched_o == $past(latch_i))
        else $error("trip did not turn the output off in the selected way");
    chk_lock_holds: assert property (st_r == G_LOCK && !(rearm_i && restart_ok_i) |=> st_r == G_LOCK)
        else $error("latched guard left lock without re-enable");
    chk_retry_period: assert property ($rose(st_r == G_COOL) |-> (st_r == G_COOL && cnt_r == '0) ##1 cnt_r == RW'(1))
        else $error("retry timer did not start from zero");
    chk_retry_restart: assert property (st_r == G_COOL && period_end && restart_ok_i |=> st_r == G_RUN)
        else $error("no restart at end of retry period");
endmodule

// *** core/pol_fault_protection_manager.sv ***
`timescale 1ns/1ps
`include "pol_cfg.svh"
module pol_fault_protection_manager
    import pol_pkg::*;
#(
    parameter int RETRY_CYC = `RETRY_CYC
) (
    input wire logic mclk_i,                    // 25 MHz clock
    input wire logic nrst_i,                    // async reset, low
    input wire logic [4:0] avs_address_i,       // byte address
    input wire logic avs_read_i,                // read request
    input wire logic avs_write_i,               // write request
    input wire logic [31:0] avs_writedata_i,    // write data
    input wire logic [3:0] avs_byteenable_i,    // byte lanes
    output logic [31:0] avs_readdata_o,         // read data
    output logic avs_waitrequest_o,             // stall
    input wire logic [15:0] vout_mv_i,          // output voltage, mV
    input wire logic [15:0] iout_ma_i,          // output current, mA
    input wire logic [7:0] temp_c_i,            // controller temperature, deg C
    input wire logic [15:0] track_ref_mv_i,     // tracking reference, mV
    input wire logic ramp_up_i,                 // output is ramping up
    output logic out_off_o,                     // output turn-off command
    output logic output_in_window_flag_o,       // power-good pin
    output logic irq_o                          // level interrupt
);
    logic [5:0] ctrl_r;
    logic [8:0] thr_r;
    logic [15:0] vset_r;
    logic [15:0] irated_r;
    logic [`IRQ_W-1:0] irq_stat_r;
    logic [`IRQ_W-1:0] irq_mask_r;
    logic [`IRQ_W-1:0] irq_stat_nxt;
    logic [`IRQ_W-1:0] irq_mask_nxt;
    logic [`IRQ_W-1:0] irq_evt;
    logic [31:0] rdata_r;
    logic wait_r;
    logic off_r;
    logic pg_r;
    logic irq_r;
    logic warn_hyst_r;
    logic warn_q;
    logic warn_d_r;
    logic pg_q;
    logic rearm;
    logic wr_go;
    logic req;
    logic [`N_GUARD-1:0] raw;
    logic [`N_GUARD-1:0] trip_q;
    logic [`N_GUARD-1:0] g_off;
    logic [`N_GUARD-1:0] g_lock;
    logic [`N_GUARD-1:0] g_evt;
    logic [`N_GUARD-1:0] restart_ok;
    logic [3:0] oc_code;
    logic [1:0] ov_code;
    logic [1:0] uv_code;
    logic [23:0] v100;
    logic [23:0] i100;
    logic [15:0] trk_diff;
    logic pg_raw;

    function automatic logic [23:0] pct_of(input logic [15:0] base, input logic [7:0] pct);
        pct_of = {8'h00, base} * {16'h0000, pct};
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        be_merge = (old & ~m) | (nw & m);
    endfunction

    // ---------------- bus slave ----------------
    // every access takes two cycles: data is fetched while waitrequest is high
    assign req = avs_read_i || avs_write_i;
    assign wr_go = avs_write_i && !wait_r;
    assign rearm = wr_go && avs_address_i == `REG_CTRL && avs_byteenable_i[1]
        && avs_writedata_i[`CTRL_REARM];

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !(req && wait_r);
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read_i && wait_r) begin
            case (avs_address_i)
                `REG_CTRL: rdata_r <= {26'h0, ctrl_r};
                `REG_THR: rdata_r <= {23'h0, thr_r};
                `REG_VSET: rdata_r <= {16'h0, vset_r};
                `REG_IRATED: rdata_r <= {16'h0, irated_r};
                `REG_STATUS: rdata_r <= {19'h0, off_r, pg_r, warn_q, g_lock, g_off};
                `REG_IRQ_STAT: rdata_r <= {25'h0, irq_stat_r};
                `REG_IRQ_MASK: rdata_r <= {25'h0, irq_mask_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // settings may change at any time and act on the next comparison
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_r <= `CTRL_RST;
            thr_r <= {`THR_PG_RST, `THR_UV_RST, `THR_OV_RST, `THR_OC_RST};
            vset_r <= `VSET_RST;
            irated_r <= `IRATED_RST;
        end else if (wr_go) begin
            case (avs_address_i)
                `REG_CTRL: ctrl_r <= 6'(be_merge({26'h0, ctrl_r}, avs_writedata_i, avs_byteenable_i));
                `REG_THR: thr_r <= 9'(be_merge({23'h0, thr_r}, avs_writedata_i, avs_byteenable_i));
                `REG_VSET: vset_r <= 16'(be_merge({16'h0, vset_r}, avs_writedata_i, avs_byteenable_i));
                `REG_IRATED: irated_r <= 16'(be_merge({16'h0, irated_r}, avs_writedata_i, avs_byteenable_i));
                default: ;
            endcase
        end
    end

    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;

    // ---------------- thresholds ----------------
    // out-of-range codes clamp to the top step
    assign oc_code = (thr_r[`THR_OC_LSB+:4] > `OC_MAXCODE) ? `OC_MAXCODE : thr_r[`THR_OC_LSB+:4];
    assign ov_code = (thr_r[`THR_OV_LSB+:2] > `OV_MAXCODE) ? `OV_MAXCODE : thr_r[`THR_OV_LSB+:2];
    assign uv_code = (thr_r[`THR_UV_LSB+:2] > `UV_MAXCODE) ? `UV_MAXCODE : thr_r[`THR_UV_LSB+:2];
    assign v100 = pct_of(vout_mv_i, 8'h64);
    assign i100 = pct_of(iout_ma_i, 8'h64);
    assign trk_diff = (vout_mv_i > track_ref_mv_i) ? vout_mv_i - track_ref_mv_i : track_ref_mv_i - vout_mv_i;

    always_comb begin
        raw = '0;
        raw[`G_OC] = i100 > pct_of(irated_r, `OC_BASE + {4'h0, oc_code} * `OC_STEP);
        raw[`G_OV] = v100 > pct_of(vset_r, `OV_BASE + {6'h00, ov_code} * `OV_STEP)
            && vout_mv_i > `OV_FLOOR_MV;
        raw[`G_UV] = !ramp_up_i && v100 < pct_of(vset_r, `UV_BASE + {6'h00, uv_code} * `UV_STEP);
        raw[`G_OT] = temp_c_i >= `OT_OFF_C;
        raw[`G_TRK] = ctrl_r[`CTRL_TRK_EN] && ramp_up_i && trk_diff > `TRK_BAND_MV;
    end

    // overtemperature may restart, by retry or by re-arm, only once cooled
    always_comb begin
        restart_ok = '1;
        restart_ok[`G_OT] = temp_c_i <= `OT_ON_C;
    end

    // ---------------- guards ----------------
    // overcurrent acts on the first sample; the others are qualified for 6 us
    for (genvar g = 0; g < `N_GUARD; g++) begin : gen_guard
        trip_filter #(
            .DLY((g == `G_OC) ? 1 : `FILT_CYC)
        ) u_filt (
            .mclk_i(mclk_i),
            .nrst_i(nrst_i),
            .cond_i(raw[g]),
            .cond_o(trip_q[g])
        );
        fault_guard #(
            .RETRY(RETRY_CYC)
        ) u_guard (
            .mclk_i(mclk_i),
            .nrst_i(nrst_i),
            .trip_i(trip_q[g]),
            .latch_i(ctrl_r[g]),
            .restart_ok_i(restart_ok[g]),
            .rearm_i(rearm),
            .off_o(g_off[g]),
            .latched_o(g_lock[g]),
            .trip_evt_o(g_evt[g])
        );
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            off_r <= 1'b0;
        end else begin
            off_r <= |g_off;
        end
    end

    // ---------------- warning ----------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            warn_hyst_r <= 1'b0;
        end else if (temp_c_i >= `WARN_ON_C) begin
            warn_hyst_r <= 1'b1;
        end else if (temp_c_i <= `WARN_ON_C - `WARN_HYST_C) begin
            warn_hyst_r <= 1'b0;
        end
    end

    trip_filter #(
        .DLY(`FILT_CYC)
    ) u_warn_filt (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .cond_i(warn_hyst_r),
        .cond_o(warn_q)
    );

    // ---------------- power-good window ----------------
    assign pg_raw = v100 >= pct_of(vset_r, `PG_BASE + (thr_r[`THR_PG] ? `PG_STEP : 8'h00))
        && v100 <= pct_of(vset_r, `PG_UPPER);

    trip_filter #(
        .DLY(`FILT_CYC)
    ) u_pg_filt (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .cond_i(pg_raw),
        .cond_o(pg_q)
    );

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pg_r <= 1'b0;
            warn_d_r <= 1'b0;
        end else begin
            pg_r <= pg_q;
            warn_d_r <= warn_q;
        end
    end

    assign output_in_window_flag_o = pg_r;
    assign out_off_o = off_r;

    // ---------------- interrupts ----------------
    always_comb begin
        irq_evt = '0;
        irq_evt[`N_GUARD-1:0] = g_evt;
        irq_evt[`IRQ_WARN] = warn_q && !warn_d_r;
        irq_evt[`IRQ_PG] = pg_q != pg_r;
        irq_mask_nxt = irq_mask_r;
        if (wr_go && avs_address_i == `REG_IRQ_MASK) begin
            irq_mask_nxt = 7'(be_merge({25'h0, irq_mask_r}, avs_writedata_i, avs_byteenable_i));
        end
        irq_stat_nxt = irq_stat_r;
        if (wr_go && avs_address_i == `REG_IRQ_STAT && avs_byteenable_i[0]) begin
            irq_stat_nxt = irq_stat_nxt & ~avs_writedata_i[`IRQ_W-1:0];
        end
        // a new event in the clearing cycle is kept
        irq_stat_nxt = irq_stat_nxt | irq_evt;
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            // next mask as well as next status, so the pin never lags a mask write
            irq_r <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    assign irq_o = irq_r;

    // ---------------- checks ----------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    chk_off_follows_guard: assert property (|g_off |=> out_off_o)
        else $error("guard off not reflected on turn-off output");
    chk_ov_floor: assert property (raw[`G_OV] |-> vout_mv_i > `OV_FLOOR_MV)
        else $error("overvoltage tripped below the 1.0 V floor");
    chk_ot_restart: assert property ($fell(g_off[`G_OT]) |-> $past(temp_c_i) <= `OT_ON_C)
        else $error("restart after overtemperature above 120 C");
    chk_ot_trip_level: assert property (temp_c_i < `OT_OFF_C |-> !raw[`G_OT])
        else $error("overtemperature raised below 130 C");
    chk_track_gate: assert property (raw[`G_TRK] |-> ctrl_r[`CTRL_TRK_EN] && ramp_up_i)
        else $error("tracking tripped while disabled or not ramping");
    chk_warn_hyst: assert property (warn_hyst_r && temp_c_i > `WARN_ON_C - `WARN_HYST_C |=> warn_hyst_r)
        else $error("warning released inside hysteresis band");
    chk_pg_upper: assert property (v100 > pct_of(vset_r, `PG_UPPER) |-> !pg_raw)
        else $error("window reported good above upper bound");
    chk_pg_pin_delay: assert property ($changed(pg_q) |=> output_in_window_flag_o == $past(pg_q))
        else $error("window pin did not follow qualified level");
    chk_irq_level: assert property (|(irq_stat_r & irq_mask_r) |-> irq_o)
        else $error("interrupt low while an unmasked status bit is set");
    chk_irq_quiet: assert property (!(|(irq_stat_r & irq_mask_r)) |-> !irq_o)
        else $error("interrupt high with no unmasked status bit");
    chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
endmodule

// *** sim/pwr_mgr_model.sv ***
`timescale 1ns/1ps
// far-side power manager: watches the good pin and counts output restarts
module pwr_mgr_model (
    input wire logic mclk_i,      // clock
    input wire logic nrst_i,      // async reset, low
    input wire logic pg_i,        // good pin
    input wire logic off_i,       // turn-off command
    input wire logic clr_i,       // clear counters
    output logic [7:0] restarts_o, // falls of off_i
    output logic [7:0] pg_drops_o  // falls of pg_i
);
    logic off_r;
    logic pg_r;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            off_r <= 1'b0;
            pg_r <= 1'b0;
        end else begin
            off_r <= off_i;
            pg_r <= pg_i;
        end
    end
    // counts saturate so a long stall never wraps to a small value
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            restarts_o <= 8'h00;
            pg_drops_o <= 8'h00;
        end else if (clr_i) begin
            restarts_o <= 8'h00;
            pg_drops_o <= 8'h00;
        end else begin
            if (off_r && !off_i && restarts_o != 8'hFF) begin
                restarts_o <= restarts_o + 8'h01;
            end
            if (pg_r && !pg_i && pg_drops_o != 8'hFF) begin
                pg_drops_o <= pg_drops_o + 8'h01;
            end
        end
    end
endmodule

// *** sim/pol_fault_protection_manager_tb.sv ***
`timescale 1ns/1ps
`include "pol_cfg.svh"
module pol_fault_protection_manager_tb;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [15:0] vout_mv_i = 16'h04B0;
    logic [15:0] iout_ma_i = 16'h0000;
    logic [7:0] temp_c_i = 8'h19;
    logic [15:0] track_ref_mv_i = 16'h0000;
    logic ramp_up_i = 1'b0;
    logic out_off_o;
    logic output_in_window_flag_o;
    logic irq_o;
    logic clr = 1'b0;
    logic [7:0] restarts;
    logic [7:0] pg_drops;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    pol_fault_protection_manager #(.RETRY_CYC(20)) i_dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .vout_mv_i(vout_mv_i),
        .iout_ma_i(iout_ma_i), .temp_c_i(temp_c_i), .track_ref_mv_i(track_ref_mv_i), .ramp_up_i(ramp_up_i),
        .out_off_o(out_off_o), .output_in_window_flag_o(output_in_window_flag_o), .irq_o(irq_o));

    pwr_mgr_model i_mgr (.mclk_i(mclk_i), .nrst_i(nrst_i), .pg_i(output_in_window_flag_o), .off_i(out_off_o),
        .clr_i(clr), .restarts_o(restarts), .pg_drops_o(pg_drops));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ceiling is several times the expected run length
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    // one access: hold until waitrequest seen low, then one idle edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        // a stalled slave is caught by the cycle ceiling
        do begin
            @(posedge mclk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask

    // output must still be old at ~145 edges and new by ~155 (150-cycle qualification)
    task automatic dly(input logic win, input logic v);
        step(145);
        chk(win ? output_in_window_flag_o : out_off_o, !v);
        step(10);
        chk(win ? output_in_window_flag_o : out_off_o, v);
    endtask

    initial begin
        step(8);
        nrst_i <= 1'b1;
        dly(1'b1, 1'b1);
        rd(`REG_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(`REG_THR, 32'hFFFFFFFF, 32'h2A);
        rd(`REG_VSET, 32'hFFFFFFFF, 32'h4B0);
        rd(`REG_IRATED, 32'hFFFFFFFF, 32'h2000);
        rd(`REG_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
        rd(5'h1C, 32'hFFFFFFFF, 32'h0);
        clr <= 1'b1;
        step(1);
        clr <= 1'b0;
        vout_mv_i <= 16'h0529;
        dly(1'b1, 1'b0);
        vout_mv_i <= 16'h0528;
        dly(1'b1, 1'b1);
        vout_mv_i <= 16'h0437;
        dly(1'b1, 1'b0);
        vout_mv_i <= 16'h0438;
        dly(1'b1, 1'b1);
        wr(`REG_THR, 32'h12A);
        vout_mv_i <= 16'h0473;
        dly(1'b1, 1'b0);
        vout_mv_i <= 16'h0474;
        dly(1'b1, 1'b1);
        chk(pg_drops, 32'h3);
        // overvoltage at default 130 percent, persistent then removed
        vout_mv_i <= 16'h0619;
        dly(1'b0, 1'b1);
        rd(`REG_STATUS, 32'h2, 32'h2);
        clr <= 1'b1;
        step(1);
        clr <= 1'b0;
        step(100);
        // 20-cycle retry plus one run cycle: 4 or 5 restarts in 100 edges
        chk(restarts >= 8'h04 && restarts <= 8'h05, 32'h1);
        vout_mv_i <= 16'h04B0;
        step(230);
        chk(out_off_o, 32'h0);
        wr(`REG_IRQ_MASK, 32'h2);
        step(2);
        chk(irq_o, 32'h1);
        wr(`REG_IRQ_STAT, 32'h2);
        step(2);
        chk(irq_o, 32'h0);
        rd(`REG_IRQ_STAT, 32'h2, 32'h0);
        wr(`REG_IRQ_MASK, 32'h0);
        wr(`REG_THR, 32'h00A);
        vout_mv_i <= 16'h0529;
        dly(1'b0, 1'b1);
        vout_mv_i <= 16'h04B0;
        step(230);
        wr(`REG_VSET, 32'h320);
        vout_mv_i <= 16'h03B6;
        step(300);
        chk(out_off_o, 32'h0);
        vout_mv_i <= 16'h03E9;
        dly(1'b0, 1'b1);
        vout_mv_i <= 16'h0320;
        step(230);
        wr(`REG_VSET, 32'h4B0);
        vout_mv_i <= 16'h04B0;
        step(200);
        // latching overvoltage stays off until re-armed
        wr(`REG_CTRL, 32'h02);
        vout_mv_i <= 16'h0529;
        dly(1'b0, 1'b1);
        vout_mv_i <= 16'h04B0;
        step(300);
        chk(out_off_o, 32'h1);
        rd(`REG_STATUS, 32'h40, 32'h40);
        wr(`REG_CTRL, 32'h102);
        step(3);
        chk(out_off_o, 32'h0);
        wr(`REG_CTRL, 32'h0);
        // overcurrent, default 180 percent of 8192 mA
        iout_ma_i <= 16'h3999;
        step(10);
        chk(out_off_o, 32'h0);
        iout_ma_i <= 16'h399A;
        step(4);
        chk(out_off_o, 32'h1);
        iout_ma_i <= 16'h0000;
        step(30);
        chk(out_off_o, 32'h0);
        wr(`REG_THR, 32'h000);
        iout_ma_i <= 16'h1333;
        step(10);
        chk(out_off_o, 32'h0);
        iout_ma_i <= 16'h1334;
        step(4);
        chk(out_off_o, 32'h1);
        iout_ma_i <= 16'h0000;
        step(30);
        wr(`REG_CTRL, 32'h01);
        iout_ma_i <= 16'h1334;
        step(4);
        iout_ma_i <= 16'h0000;
        step(60);
        chk(out_off_o, 32'h1);
        wr(`REG_CTRL, 32'h101);
        step(3);
        chk(out_off_o, 32'h0);
        wr(`REG_CTRL, 32'h0);
        // undervoltage is masked while ramping; tracking still disabled
        ramp_up_i <= 1'b1;
        vout_mv_i <= 16'h0383;
        step(300);
        chk(out_off_o, 32'h0);
        ramp_up_i <= 1'b0;
        dly(1'b0, 1'b1);
        vout_mv_i <= 16'h04B0;
        step(230);
        wr(`REG_THR, 32'h080);
        vout_mv_i <= 16'h03FB;
        dly(1'b0, 1'b1);
        vout_mv_i <= 16'h04B0;
        step(230);
        wr(`REG_CTRL, 32'h20);
        ramp_up_i <= 1'b1;
        track_ref_mv_i <= 16'h03B6;
        step(300);
        chk(out_off_o, 32'h0);
        vout_mv_i <= 16'h04B1;
        dly(1'b0, 1'b1);
        ramp_up_i <= 1'b0;
        step(230);
        chk(out_off_o, 32'h0);
        wr(`REG_CTRL, 32'h0);
        // warning with hysteresis, then overtemperature shutdown
        temp_c_i <= 8'h77;
        step(300);
        rd(`REG_IRQ_STAT, 32'h20, 32'h0);
        rd(`REG_STATUS, 32'h400, 32'h0);
        temp_c_i <= 8'h78;
        step(140);
        rd(`REG_STATUS, 32'h400, 32'h0);
        step(15);
        rd(`REG_STATUS, 32'h400, 32'h400);
        rd(`REG_IRQ_STAT, 32'h20, 32'h20);
        temp_c_i <= 8'h76;
        step(300);
        rd(`REG_STATUS, 32'h400, 32'h400);
        temp_c_i <= 8'h75;
        step(160);
        rd(`REG_STATUS, 32'h400, 32'h0);
        temp_c_i <= 8'h81;
        step(300);
        chk(out_off_o, 32'h0);
        temp_c_i <= 8'h82;
        dly(1'b0, 1'b1);
        temp_c_i <= 8'h79;
        step(300);
        chk(out_off_o, 32'h1);
        temp_c_i <= 8'h78;
        step(230);
        chk(out_off_o, 32'h0);
        end_of_test();
    end
endmodule
